// File: hdl/cmlr_pkg.sv
/*
  Shared constants for the move, logic, rotate and return execute unit:
  operation codes, register offsets, field positions and reset values.
  Assumes the decoder upstream already maps opcodes onto these codes.
*/
package cmlr_pkg;

  // Operation codes presented on the instruction port
  localparam logic [3:0] OP_IDLE   = 4'h0;
  localparam logic [3:0] OP_OR     = 4'h1;
  localparam logic [3:0] OP_STORE  = 4'h2;
  localparam logic [3:0] OP_COPY   = 4'h3;
  localparam logic [3:0] OP_IRQRET = 4'h4;
  localparam logic [3:0] OP_RETLIT = 4'h5;
  localparam logic [3:0] OP_ROTL   = 4'h6;
  localparam logic [3:0] OP_ROTR   = 4'h7;

  // Sizes
  localparam int FILE_AW  = 7;
  localparam int PC_W     = 13;
  localparam int STK_AW   = 3;
  localparam int STK_SIZE = 8;

  // Register port map (8-bit address)
  localparam logic [7:0] OFS_ACC     = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h01;
  localparam logic [7:0] OFS_PC_LO   = 8'h02;
  localparam logic [7:0] OFS_PC_HI   = 8'h03;
  localparam logic [7:0] OFS_STK_PTR = 8'h04;
  localparam logic [7:0] OFS_PUSH_LO = 8'h05;
  localparam logic [7:0] OFS_PUSH_HI = 8'h06;
  localparam logic [7:0] OFS_FILE    = 8'h80;

  // Status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO  = 1;
  localparam int ST_GIE   = 2;

  // Reset values
  localparam logic [7:0]      RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC   = 13'h0000;

endpackage : cmlr_pkg

// File: hdl/cmlr_alu.sv
/*
  Datapath for the execute unit: OR, copy, store and the two rotates
  through carry. Purely combinational.
  Assumes the caller chooses where the result goes and which flags stick.
*/
`timescale 1ns/1ps
module cmlr_alu (
  // Operation
  input  wire logic [3:0] op_i,
  // Operands
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] file_i,
  input  wire logic       carry_i,
  // Results
  output logic      [7:0] result_o,
  output logic            carry_o,
  output logic            zero_o
);

  always_comb begin
    result_o = file_i;
    carry_o  = carry_i;
    case (op_i)
      cmlr_pkg::OP_OR: begin
        result_o = acc_i | file_i; // [RULE1]
      end
      cmlr_pkg::OP_STORE: begin
        result_o = acc_i; // [RULE3]
      end
      cmlr_pkg::OP_COPY: begin
        result_o = file_i; // [RULE4]
      end
      cmlr_pkg::OP_ROTL: begin
        result_o = {file_i[6:0], carry_i}; // [RULE8]
        carry_o  = file_i[7]; // [RULE8]
      end
      cmlr_pkg::OP_ROTR: begin
        result_o = {carry_i, file_i[7:1]}; // [RULE9]
        carry_o  = file_i[0]; // [RULE9]
      end
      default: begin
        result_o = file_i;
      end
    endcase
    zero_o = (result_o == 8'h00);
  end

endmodule : cmlr_alu

// File: hdl/cmlr_core.sv
/*
  Execute unit for OR with register, store accumulator, copy register,
  idle, interrupt return, return with literal and rotates through carry.
  Holds the accumulator, status flags, program counter, the 8-entry
  return stack and a 128-byte register file, all but the stack entries readable over a plain
  register port. Assumes a decoder that presents one operation per
  accepted cycle and honours instr_ready_o.
*/
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] OR accumulator with addressed register 0..127; only zero flag changes.
// [RULE2] OR result goes to accumulator if target bit 0, register if 1.
// [RULE3] Store copies accumulator into register 0..127; flags untouched.
// [RULE4] Copy moves register to accumulator or itself by target bit; sets zero.
// [RULE5] Copy with target 1 keeps register value but zero flag tests it.
// [RULE6] Return with literal loads accumulator, pops stack to PC; flags kept.
// [RULE7] Return with literal takes two instruction cycles.
// [RULE8] Rotate left: carry into bit 0, bit 7 into carry; target by bit.
// [RULE9] Rotate right: carry into bit 7, bit 0 into carry; target by bit.
// [RULE10] Idle changes nothing but advances the program counter.
// [RULE11] Interrupt return pops stack to PC, sets global enable; flags kept.
module cmlr_core (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  // Instruction port
  input  wire logic                       instr_valid_i,
  output logic                            instr_ready_o,
  input  wire logic [3:0]                 instr_op_i,
  input  wire logic [cmlr_pkg::FILE_AW-1:0] instr_addr_i,
  input  wire logic                       instr_dest_i,
  input  wire logic [7:0]                 instr_lit_i,
  // Register port
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [7:0]                 reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [7:0]                 reg_rdata_o,
  // Core state
  output logic      [cmlr_pkg::PC_W-1:0]  pc_o,
  output logic                            global_irq_enable_o
);

  ////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic [1:0] {
    CMLR_EXEC  = 2'b01,
    CMLR_FLUSH = 2'b10
  } cmlr_state_e;

  localparam int FILE_N = 1 << cmlr_pkg::FILE_AW;

  cmlr_state_e                  state_reg, state_next;
  logic [7:0]                   acc_reg, acc_next;
  logic                         carry_reg, carry_next;
  logic                         zero_reg, zero_next;
  logic                         gie_reg, gie_next;
  logic [cmlr_pkg::PC_W-1:0]    pc_reg, pc_next;
  logic [cmlr_pkg::STK_AW-1:0]  sp_reg, sp_next;
  logic [7:0]                   push_lo_reg, push_lo_next;
  logic [7:0]                   rdata_reg, rdata_next;
  logic [cmlr_pkg::PC_W-1:0]    stack_reg [cmlr_pkg::STK_SIZE];
  logic [7:0]                   file_reg  [FILE_N];

  logic                         fire;
  logic [7:0]                   file_rd;
  logic [7:0]                   alu_result;
  logic                         alu_carry;
  logic                         alu_zero;
  logic                         file_we;
  logic [cmlr_pkg::FILE_AW-1:0] file_wa;
  logic [7:0]                   file_wd;
  logic                         stk_push;
  logic [cmlr_pkg::STK_AW-1:0]  sp_dec;
  logic                         bus_file;
  logic [cmlr_pkg::FILE_AW-1:0] bus_fa;

  ////////////////////////////////////////////////////////////////////////
  // Datapath

  // Second cycle of a two-cycle return refuses new instructions
  assign instr_ready_o = (state_reg == CMLR_EXEC); // [RULE7]
  assign fire          = instr_valid_i && instr_ready_o;
  assign file_rd       = file_reg[instr_addr_i]; // [RULE1]
  assign sp_dec        = sp_reg - 3'h1;
  assign bus_file      = reg_addr_i[7];
  assign bus_fa        = reg_addr_i[cmlr_pkg::FILE_AW-1:0];

  cmlr_alu u_alu (
    .op_i     (instr_op_i),
    .acc_i    (acc_reg),
    .file_i   (file_rd),
    .carry_i  (carry_reg),
    .result_o (alu_result),
    .carry_o  (alu_carry),
    .zero_o   (alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////
  // Execute and register port, next state

  always_comb begin
    state_next   = state_reg;
    acc_next     = acc_reg;
    carry_next   = carry_reg;
    zero_next    = zero_reg;
    gie_next     = gie_reg;
    pc_next      = pc_reg;
    sp_next      = sp_reg;
    push_lo_next = push_lo_reg;
    rdata_next   = reg_rdata_o;
    file_we      = 1'b0;
    file_wa      = bus_fa;
    file_wd      = reg_wdata_i;
    stk_push     = 1'b0;

    // Software writes; an instruction in the same cycle overrides below
    if (reg_wr_i) begin
      if (bus_file) begin
        file_we = 1'b1;
      end else if (reg_addr_i == cmlr_pkg::OFS_ACC) begin
        acc_next = reg_wdata_i;
      end else if (reg_addr_i == cmlr_pkg::OFS_STATUS) begin
        carry_next = reg_wdata_i[cmlr_pkg::ST_CARRY];
        zero_next  = reg_wdata_i[cmlr_pkg::ST_ZERO];
        gie_next   = reg_wdata_i[cmlr_pkg::ST_GIE];
      end else if (reg_addr_i == cmlr_pkg::OFS_PC_LO) begin
        pc_next[7:0] = reg_wdata_i;
      end else if (reg_addr_i == cmlr_pkg::OFS_PC_HI) begin
        pc_next[cmlr_pkg::PC_W-1:8] = reg_wdata_i[cmlr_pkg::PC_W-9:0];
      end else if (reg_addr_i == cmlr_pkg::OFS_STK_PTR) begin
        sp_next = reg_wdata_i[cmlr_pkg::STK_AW-1:0];
      end else if (reg_addr_i == cmlr_pkg::OFS_PUSH_LO) begin
        push_lo_next = reg_wdata_i;
      end else if (reg_addr_i == cmlr_pkg::OFS_PUSH_HI) begin
        // Stack wraps like the hardware stack: the ninth push overwrites
        stk_push = 1'b1;
        sp_next  = sp_reg + 3'h1;
      end
    end

    case (state_reg)
      CMLR_EXEC: begin
        if (fire) begin
          pc_next = pc_reg + 13'h0001; // [RULE10]
          case (instr_op_i)
            cmlr_pkg::OP_OR, cmlr_pkg::OP_COPY: begin
              zero_next = alu_zero; // [RULE1]
              if (instr_dest_i) begin
                // Copy to itself rewrites the same value: a zero test
                file_we = 1'b1; // [RULE2] [RULE5]
                file_wa = instr_addr_i;
                file_wd = alu_result;
              end else begin
                acc_next = alu_result; // [RULE2] [RULE4]
              end
            end
            cmlr_pkg::OP_STORE: begin
              file_we = 1'b1; // [RULE3]
              file_wa = instr_addr_i;
              file_wd = alu_result;
            end
            cmlr_pkg::OP_ROTL, cmlr_pkg::OP_ROTR: begin
              carry_next = alu_carry; // [RULE8] [RULE9]
              if (instr_dest_i) begin
                file_we = 1'b1; // [RULE8] [RULE9]
                file_wa = instr_addr_i;
                file_wd = alu_result;
              end else begin
                acc_next = alu_result; // [RULE8] [RULE9]
              end
            end
            cmlr_pkg::OP_IRQRET: begin
              pc_next  = stack_reg[sp_dec]; // [RULE11]
              sp_next  = sp_dec; // [RULE11]
              gie_next = 1'b1; // [RULE11]
              stk_push = 1'b0;
              state_next = CMLR_FLUSH;
            end
            cmlr_pkg::OP_RETLIT: begin
              acc_next   = instr_lit_i; // [RULE6]
              pc_next    = stack_reg[sp_dec]; // [RULE6]
              sp_next    = sp_dec; // [RULE6]
              stk_push   = 1'b0;
              state_next = CMLR_FLUSH; // [RULE7]
            end
            default: begin
              // Idle and unknown codes only advance the counter
            end
          endcase
        end
      end
      CMLR_FLUSH: begin
        state_next = CMLR_EXEC; // [RULE7]
      end
      default: begin
        state_next = CMLR_EXEC;
      end
    endcase

    // Read data reflect state before this cycle's writes
    if (reg_rd_i) begin
      if (bus_file) begin
        rdata_next = file_reg[bus_fa];
      end else if (reg_addr_i == cmlr_pkg::OFS_ACC) begin
        rdata_next = acc_reg;
      end else if (reg_addr_i == cmlr_pkg::OFS_STATUS) begin
        rdata_next = {5'h00, gie_reg, zero_reg, carry_reg};
      end else if (reg_addr_i == cmlr_pkg::OFS_PC_LO) begin
        rdata_next = pc_reg[7:0];
      end else if (reg_addr_i == cmlr_pkg::OFS_PC_HI) begin
        rdata_next = {3'h0, pc_reg[cmlr_pkg::PC_W-1:8]};
      end else if (reg_addr_i == cmlr_pkg::OFS_STK_PTR) begin
        rdata_next = {5'h00, sp_reg};
      end else if (reg_addr_i == cmlr_pkg::OFS_PUSH_LO) begin
        rdata_next = push_lo_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end else begin
      rdata_next = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg   <= CMLR_EXEC;
      acc_reg     <= cmlr_pkg::RST_BYTE;
      carry_reg   <= 1'b0;
      zero_reg    <= 1'b0;
      gie_reg     <= 1'b0;
      pc_reg      <= cmlr_pkg::RST_PC;
      sp_reg      <= 3'h0;
      push_lo_reg <= cmlr_pkg::RST_BYTE;
      rdata_reg   <= cmlr_pkg::RST_BYTE;
    end else begin
      state_reg   <= state_next;
      acc_reg     <= acc_next;
      carry_reg   <= carry_next;
      zero_reg    <= zero_next;
      gie_reg     <= gie_next;
      pc_reg      <= pc_next;
      sp_reg      <= sp_next;
      push_lo_reg <= push_lo_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign reg_rdata_o         = rdata_reg;
  assign pc_o                = pc_reg;
  assign global_irq_enable_o = gie_reg;

  // Register file: one write port, shared by bus and execute
  for (genvar gi = 0; gi < FILE_N; gi++) begin : g_file
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        file_reg[gi] <= cmlr_pkg::RST_BYTE;
      end else if (file_we && (int'(file_wa) == gi)) begin
        file_reg[gi] <= file_wd;
      end
    end
  end

  // Return stack, filled by software through the push registers
  for (genvar gs = 0; gs < cmlr_pkg::STK_SIZE; gs++) begin : g_stack
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        stack_reg[gs] <= cmlr_pkg::RST_PC;
      end else if (stk_push && (int'(sp_reg) == gs)) begin
        stack_reg[gs] <= {reg_wdata_i[cmlr_pkg::PC_W-9:0], push_lo_reg};
      end
    end
  end

endmodule : cmlr_core

// File: bench/cmlr_core_props.sv
/* Port checker for cmlr_core.
   Assumes the bind below reaches every cmlr_core instance. */
`timescale 1ns/1ps
module cmlr_core_props (
  // Clock and reset
  input wire logic                      clk_i,
  input wire logic                      arst_n_i,
  // Instruction port
  input wire logic                      instr_valid_i,
  input wire logic                      instr_ready_o,
  input wire logic [3:0]                instr_op_i,
  input wire logic [7:0]                instr_lit_i,
  // Register port
  input wire logic [7:0]                reg_addr_i,
  input wire logic                      reg_wr_i,
  input wire logic                      reg_rd_i,
  input wire logic [7:0]                reg_rdata_o,
  // Core state
  input wire logic [cmlr_pkg::PC_W-1:0] pc_o,
  input wire logic                      global_irq_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic take;
  logic ret;
  logic irq;
  assign take = instr_valid_i && instr_ready_o;
  assign irq  = take && instr_op_i == cmlr_pkg::OP_IRQRET;
  assign ret  = irq || (take && instr_op_i == cmlr_pkg::OP_RETLIT);
  ret_bubble_a: assert property (ret |=> !instr_ready_o)
    else $error("no refused cycle after a return");
  ret_resume_a: assert property (ret |=> ##1 instr_ready_o)
    else $error("return held longer than two cycles");
  plain_ready_a: assert property (take && !ret |=> instr_ready_o)
    else $error("ordinary instruction stalled");
  pc_step_a: assert property (take && !ret && !reg_wr_i
    |=> pc_o == $past(pc_o) + 1'b1) else $error("pc did not step");
  pc_hold_a: assert property (!take && !reg_wr_i
    |=> $stable(pc_o)) else $error("pc moved without work");
  gie_set_a: assert property (irq |=> global_irq_enable_o)
    else $error("interrupt return left enable low");
  gie_hold_a: assert property (!irq && !reg_wr_i
    |=> $stable(global_irq_enable_o)) else $error("enable moved");
  lit_acc_a: assert property ((take && instr_op_i == cmlr_pkg::OP_RETLIT
    ##1 reg_rd_i && reg_addr_i == cmlr_pkg::OFS_ACC)
    |=> reg_rdata_o == $past(instr_lit_i, 2)) else $error("bad literal");
endmodule : cmlr_core_props

bind cmlr_core cmlr_core_props cmlr_core_props_inst (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
  .instr_ready_o(instr_ready_o), .instr_op_i(instr_op_i),
  .instr_lit_i(instr_lit_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .pc_o(pc_o), .global_irq_enable_o(global_irq_enable_o));

// File: bench/tb.sv
/* Self-checking bench for cmlr_core; drives all ports directly.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        instr_valid_i = 1'b0;
  logic        instr_ready_o;
  logic [3:0]  instr_op_i = 4'h0;
  logic [6:0]  instr_addr_i = 7'h00;
  logic        instr_dest_i = 1'b0;
  logic [7:0]  instr_lit_i = 8'h00;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [12:0] pc_o;
  logic        global_irq_enable_o;
  int          err_count = 0;
  int          comparisons = 0;

  always #4 clk_i = ~clk_i;

  cmlr_core cmlr_core_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
    .instr_op_i(instr_op_i), .instr_addr_i(instr_addr_i),
    .instr_dest_i(instr_dest_i), .instr_lit_i(instr_lit_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pc_o(pc_o), .global_irq_enable_o(global_irq_enable_o));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd

  task automatic exe(input logic [3:0] op, input logic [6:0] a,
                     input logic d, input logic [7:0] k);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i    <= op;
    instr_addr_i  <= a;
    instr_dest_i  <= d;
    instr_lit_i   <= k;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
  endtask : exe

  ////////////////////////////////////////////////////////////////////////
  task automatic t_or;
    wr(8'h00, 8'h0f);
    wr(8'hff, 8'h30);
    wr(8'h01, 8'h03);
    exe(cmlr_pkg::OP_OR, 7'h7f, 1'b0, 8'h00);
    rd(8'h00, 8'h3f);
    rd(8'h01, 8'h01);
    wr(8'h00, 8'h0c);
    wr(8'h80, 8'h41);
    wr(8'h01, 8'h02);
    exe(cmlr_pkg::OP_OR, 7'h00, 1'b1, 8'h00);
    rd(8'h80, 8'h4d);
    rd(8'h00, 8'h0c);
    rd(8'h01, 8'h00);
  endtask : t_or

  task automatic t_store;
    wr(8'h00, 8'ha5);
    wr(8'h01, 8'h03);
    exe(cmlr_pkg::OP_STORE, 7'h05, 1'b0, 8'h00);
    rd(8'h85, 8'ha5);
    rd(8'h01, 8'h03);
  endtask : t_store

  task automatic t_copy;
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h02);
    exe(cmlr_pkg::OP_COPY, 7'h05, 1'b0, 8'h00);
    rd(8'h00, 8'ha5);
    rd(8'h01, 8'h00);
    wr(8'h86, 8'h00);
    wr(8'h01, 8'h01);
    exe(cmlr_pkg::OP_COPY, 7'h06, 1'b1, 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h01, 8'h03);
    rd(8'h00, 8'ha5);
  endtask : t_copy

  // Both carry inputs and both targets; zero flag preset to catch leaks
  task automatic t_rot;
    logic c;
    logic d;
    for (int i = 0; i < 4; i++) begin
      c = i[0];
      d = i[1];
      wr(8'h00, 8'h11);
      wr(8'h89, 8'h81);
      wr(8'h01, {7'h01, c});
      exe(cmlr_pkg::OP_ROTL, 7'h09, d, 8'h00);
      rd(d ? 8'h89 : 8'h00, {7'h01, c});
      rd(d ? 8'h00 : 8'h89, d ? 8'h11 : 8'h81);
      rd(8'h01, 8'h03);
      wr(8'h89, 8'h80);
      wr(8'h01, {7'h01, c});
      exe(cmlr_pkg::OP_ROTR, 7'h09, d, 8'h00);
      rd(d ? 8'h89 : 8'h00, {c, 7'h40});
      rd(8'h01, 8'h02);
    end
  endtask : t_rot

  // Last rotate right leaves 0xc0 in register 9; idle with target 1 must keep it
  task automatic t_idle;
    logic [12:0] p;
    wr(8'h00, 8'h5c);
    wr(8'h01, 8'h03);
    #1 p = pc_o;
    exe(cmlr_pkg::OP_IDLE, 7'h09, 1'b1, 8'h00);
    #1 chk(pc_o, p + 13'h0001);
    rd(8'h00, 8'h5c);
    rd(8'h01, 8'h03);
    rd(8'h89, 8'hc0);
  endtask : t_idle

  // A copy offered in the refused cycle must be dropped
  task automatic t_retlit;
    wr(8'h05, 8'h23);
    wr(8'h06, 8'h01);
    wr(8'h89, 8'h99);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i    <= cmlr_pkg::OP_RETLIT;
    instr_lit_i   <= 8'h33;
    @(posedge clk_i);
    instr_op_i   <= cmlr_pkg::OP_COPY;
    instr_dest_i <= 1'b0;
    reg_rd_i     <= 1'b1;
    reg_addr_i   <= 8'h00;
    #1 chk(instr_ready_o, 16'h0000);
    chk(pc_o, 16'h0123);
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    reg_rd_i      <= 1'b0;
    #1 chk(reg_rdata_o, 16'h0033);
    chk(instr_ready_o, 16'h0001);
    chk(pc_o, 16'h0123);
    rd(8'h00, 8'h33);
    rd(8'h01, 8'h03);
    rd(8'h04, 8'h00);
  endtask : t_retlit

  task automatic t_irqret;
    wr(8'h05, 8'hbc);
    wr(8'h06, 8'h0a);
    exe(cmlr_pkg::OP_IRQRET, 7'h00, 1'b0, 8'h00);
    #1 chk(pc_o, 16'h0abc);
    chk(global_irq_enable_o, 16'h0001);
    rd(8'h01, 8'h07);
  endtask : t_irqret

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_or;
    t_store;
    t_copy;
    t_rot;
    t_idle;
    t_retlit;
    t_irqret;
    report_and_stop;
  end

  // Whole run needs well under 500 cycles
  initial begin
    repeat (2000) @(posedge clk_i);
    err_count++;
    report_and_stop;
  end
endmodule : tb
